// File: verilog/pump_sleep_wake_controller.sv
// Sleep and wake sequencer for a constant pressure pump drive
`timescale 1ns/1ps

// Operation
// R1: Sleep needs pressure at target or switch
// R2: Sleep needs low frequency or high pressure
// R3: Sleep needs on-time above selected minimum
// R4: Analog boost raises target, sleeps when reached
// R5: Analog sleep restarts below target minus drop
// R6: High pressure threshold is target plus offset
// R7: Analog high pressure stops drive into sleep
// R8: Sleep frequency threshold is minimum plus offset
// R9: Digital mode ignores drop, restarts on switch
// R10: Digital boost raises speed limit for time
// R11: Off period picks long or short on-time
// R12: Equal off period picks short; restart starts timer
// R13: Sequencer active only in constant pressure mode
module pump_sleep_wake_controller #(
   parameter int PRESSURE_W = pump_sleep_pkg::PRESSURE_W,
   parameter int FREQ_W = pump_sleep_pkg::FREQ_W,
   parameter int TIME_W = pump_sleep_pkg::TIME_W,
   parameter int BOOST_W = pump_sleep_pkg::BOOST_W,
   parameter int TICKS_PER_SECOND = pump_sleep_pkg::TICKS_PER_SECOND
) (
   // Clock, reset, enable
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic clk_en_in,
   // Mode selection
   input wire logic cp_mode_in,
   input wire logic digital_mode_in,
   // Pressure inputs
   input wire logic [PRESSURE_W-1:0] pressure_in,
   input wire logic switch_reached_in,
   input wire logic [PRESSURE_W-1:0] target_pressure_in,
   input wire logic [PRESSURE_W-1:0] restart_pressure_drop_in,
   input wire logic [PRESSURE_W-1:0] high_pressure_offset_in,
   input wire logic high_pressure_offset_load_in,
   input wire logic [BOOST_W-1:0] boost_amount_in,
   // Frequency inputs
   input wire logic [FREQ_W-1:0] out_frequency_in,
   input wire logic [FREQ_W-1:0] min_frequency_in,
   input wire logic [FREQ_W-1:0] max_frequency_in,
   input wire logic [FREQ_W-1:0] sleep_frequency_offset_in,
   // On and off timer settings in seconds
   input wire logic [TIME_W-1:0] off_time_threshold_in,
   input wire logic [TIME_W-1:0] long_min_on_time_in,
   input wire logic [TIME_W-1:0] short_min_on_time_in,
   // Motor commands
   output logic run_out,
   output logic sleep_out,
   output logic boost_out,
   output logic [PRESSURE_W:0] pressure_target_out,
   output logic [FREQ_W:0] speed_limit_out,
   // Status
   output logic cp_active_out,
   output logic [TIME_W-1:0] min_on_time_out,
   output logic on_time_met_out,
   output logic [PRESSURE_W:0] high_pressure_sleep_threshold_out,
   output logic [FREQ_W:0] sleep_frequency_threshold_out
);

   // ************************************************************
   // Parameter checks
   // ************************************************************
   if (PRESSURE_W < 2 || FREQ_W < 2 || TIME_W < 2 || BOOST_W < 1 || TICKS_PER_SECOND < 1) begin : g_check
      $error("pump_sleep_wake_controller: bad parameters");
   end

   localparam int SPEED_W = FREQ_W + BOOST_W + 8;
   localparam logic [SPEED_W-1:0] PERCENT = SPEED_W'(pump_sleep_pkg::PERCENT_FULL);
   localparam logic [TIME_W-1:0] BOOST_STEP = TIME_W'(pump_sleep_pkg::BOOST_SECONDS_PER_STEP);

   // ************************************************************
   // State
   // ************************************************************
   pump_sleep_pkg::seq_state_t state_r;
   pump_sleep_pkg::seq_state_t state_nxt;
   logic [PRESSURE_W-1:0] hp_offset_r;
   logic long_sel_r;
   logic restart_evt;

   logic run_r;
   logic sleep_r;
   logic boost_r;
   logic [PRESSURE_W:0] pressure_target_r;
   logic [FREQ_W:0] speed_limit_r;
   logic cp_active_r;
   logic [TIME_W-1:0] min_on_time_r;
   logic on_time_met_r;
   logic [PRESSURE_W:0] hp_thr_r;
   logic [FREQ_W:0] freq_thr_r;

   logic [TIME_W-1:0] on_secs;
   logic [TIME_W-1:0] off_secs;
   logic [TIME_W-1:0] boost_secs;

   // ************************************************************
   // Thresholds
   // ************************************************************
   wire analog_mode = ~digital_mode_in;
   wire [PRESSURE_W:0] pressure_x = {1'b0, pressure_in};
   wire [PRESSURE_W:0] target_x = {1'b0, target_pressure_in};
   wire [PRESSURE_W:0] hp_thr = target_x + {1'b0, hp_offset_r}; // [R6]
   wire [FREQ_W:0] freq_thr = {1'b0, min_frequency_in} + {1'b0, sleep_frequency_offset_in}; // [R8]
   wire [PRESSURE_W:0] boost_x = (PRESSURE_W+1)'(boost_amount_in);
   wire [PRESSURE_W:0] boosted_target = target_x + boost_x; // [R4]
   wire [PRESSURE_W:0] drop_x = {1'b0, restart_pressure_drop_in};

   // ************************************************************
   // Sleep conditions
   // ************************************************************
   wire at_target = analog_mode ? (pressure_in == target_pressure_in) : switch_reached_in; // [R1]
   wire below_freq = {1'b0, out_frequency_in} < freq_thr; // [R2] [R8]
   wire over_pressure = analog_mode & (pressure_x > hp_thr); // [R2] [R7]
   wire hp_hit = analog_mode & (pressure_x >= hp_thr); // [R7]
   wire [TIME_W-1:0] min_on = long_sel_r ? long_min_on_time_in : short_min_on_time_in; // [R11]
   wire on_time_met = on_secs > min_on; // [R3]
   wire sleep_ready = at_target & (below_freq | over_pressure) & on_time_met; // [R1] [R2] [R3]

   // ************************************************************
   // Boost completion and restart
   // ************************************************************
   wire boost_reached = pressure_x >= boosted_target; // [R4]
   wire [TIME_W-1:0] boost_limit = TIME_W'(boost_amount_in) * BOOST_STEP;
   wire boost_done = boost_secs >= boost_limit; // [R10]
   wire boost_finish = analog_mode ? boost_reached : boost_done;
   wire analog_restart = (pressure_x + drop_x) < target_x; // [R5]
   wire digital_restart = ~switch_reached_in; // [R9]
   wire restart_req = analog_mode ? analog_restart : digital_restart;
   wire off_long = off_secs > off_time_threshold_in; // [R11] [R12]

   // ************************************************************
   // Boosted speed limit for digital mode
   // ************************************************************
   wire [SPEED_W-1:0] max_x = SPEED_W'(max_frequency_in);
   wire [SPEED_W-1:0] pct_x = PERCENT + SPEED_W'(boost_amount_in);
   wire [SPEED_W-1:0] speed_prod = max_x * pct_x;
   wire [SPEED_W-1:0] speed_quot = speed_prod / PERCENT; // [R10]
   wire [FREQ_W:0] boosted_speed = speed_quot[FREQ_W:0];

   // ************************************************************
   // Timer controls
   // ************************************************************
   wire enter_run = (state_nxt == pump_sleep_pkg::ST_RUN) && (state_r != pump_sleep_pkg::ST_RUN);
   wire enter_sleep = (state_nxt == pump_sleep_pkg::ST_SLEEP) && (state_r != pump_sleep_pkg::ST_SLEEP);
   wire enter_boost = (state_nxt == pump_sleep_pkg::ST_BOOST) && (state_r != pump_sleep_pkg::ST_BOOST);
   wire motor_on = (state_r == pump_sleep_pkg::ST_RUN) || (state_r == pump_sleep_pkg::ST_BOOST);
   wire sleeping = (state_r == pump_sleep_pkg::ST_SLEEP);
   wire boosting = (state_r == pump_sleep_pkg::ST_BOOST);

   // ************************************************************
   // Output next values
   // ************************************************************
   wire nxt_sleep = (state_nxt == pump_sleep_pkg::ST_SLEEP);
   wire nxt_boost = (state_nxt == pump_sleep_pkg::ST_BOOST);
   wire [PRESSURE_W:0] target_nxt = (nxt_boost && analog_mode) ? boosted_target : target_x; // [R4]
   wire [FREQ_W:0] limit_nxt = (nxt_boost && digital_mode_in) ? boosted_speed : {1'b0, max_frequency_in}; // [R10]

   // ************************************************************
   // Sequencer next state
   // ************************************************************
   always_comb begin
      state_nxt = state_r;
      restart_evt = 1'b0;
      if (!cp_mode_in) begin
         state_nxt = pump_sleep_pkg::ST_IDLE; // [R13]
      end else begin
         unique case (state_r)
            pump_sleep_pkg::ST_IDLE: begin
               state_nxt = pump_sleep_pkg::ST_RUN;
            end
            pump_sleep_pkg::ST_RUN: begin
               if (hp_hit) begin
                  state_nxt = pump_sleep_pkg::ST_SLEEP; // [R7]
               end else if (sleep_ready) begin
                  state_nxt = pump_sleep_pkg::ST_BOOST; // [R4] [R10]
               end
            end
            pump_sleep_pkg::ST_BOOST: begin
               if (hp_hit || boost_finish) begin
                  state_nxt = pump_sleep_pkg::ST_SLEEP; // [R4] [R7] [R10]
               end
            end
            pump_sleep_pkg::ST_SLEEP: begin
               if (restart_req) begin
                  state_nxt = pump_sleep_pkg::ST_RUN; // [R5] [R9]
                  restart_evt = 1'b1;
               end
            end
         endcase
      end
   end

   // ************************************************************
   // State registers
   // ************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         state_r <= pump_sleep_pkg::ST_IDLE;
         long_sel_r <= pump_sleep_pkg::LONG_SEL_RESET;
      end else if (clk_en_in) begin
         state_r <= state_nxt;
         if (restart_evt) begin
            long_sel_r <= off_long; // [R11] [R12]
         end
      end
   end

   // ************************************************************
   // High pressure offset setting
   // ************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         hp_offset_r <= pump_sleep_pkg::HIGH_PRESSURE_OFFSET_DEFAULT; // [R6]
      end else if (clk_en_in && high_pressure_offset_load_in) begin
         hp_offset_r <= high_pressure_offset_in;
      end
   end

   // ************************************************************
   // Registered outputs
   // ************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         run_r <= 1'b0;
         sleep_r <= 1'b0;
         boost_r <= 1'b0;
         pressure_target_r <= '0;
         speed_limit_r <= '0;
         cp_active_r <= 1'b0;
      end else if (clk_en_in) begin
         run_r <= ~nxt_sleep; // [R13]
         sleep_r <= nxt_sleep;
         boost_r <= nxt_boost;
         pressure_target_r <= target_nxt;
         speed_limit_r <= limit_nxt;
         cp_active_r <= cp_mode_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         min_on_time_r <= '0;
         on_time_met_r <= 1'b0;
         hp_thr_r <= '0;
         freq_thr_r <= '0;
      end else if (clk_en_in) begin
         min_on_time_r <= min_on;
         on_time_met_r <= on_time_met;
         hp_thr_r <= hp_thr;
         freq_thr_r <= freq_thr;
      end
   end

   // ************************************************************
   // On, off and boost timers
   // ************************************************************
   second_timer #(
      .TIME_W(TIME_W),
      .TICKS(TICKS_PER_SECOND)
   ) u_on_timer (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .clk_en_in(clk_en_in),
      .clear_in(enter_run), // [R12]
      .count_in(motor_on),
      .seconds_out(on_secs)
   );

   second_timer #(
      .TIME_W(TIME_W),
      .TICKS(TICKS_PER_SECOND)
   ) u_off_timer (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .clk_en_in(clk_en_in),
      .clear_in(enter_sleep), // [R11]
      .count_in(sleeping),
      .seconds_out(off_secs)
   );

   second_timer #(
      .TIME_W(TIME_W),
      .TICKS(TICKS_PER_SECOND)
   ) u_boost_timer (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .clk_en_in(clk_en_in),
      .clear_in(enter_boost), // [R10]
      .count_in(boosting),
      .seconds_out(boost_secs)
   );

   // ************************************************************
   // Output drive
   // ************************************************************
   assign run_out = run_r;
   assign sleep_out = sleep_r;
   assign boost_out = boost_r;
   assign pressure_target_out = pressure_target_r;
   assign speed_limit_out = speed_limit_r;
   assign cp_active_out = cp_active_r;
   assign min_on_time_out = min_on_time_r;
   assign on_time_met_out = on_time_met_r;
   assign high_pressure_sleep_threshold_out = hp_thr_r;
   assign sleep_frequency_threshold_out = freq_thr_r;

endmodule

// File: verilog/pump_sleep_pkg.sv
// Constants and types shared by the pump sleep and wake sequencer
package pump_sleep_pkg;

   // ************************************************************
   // Data widths
   // ************************************************************
   localparam int PRESSURE_W = 10;
   localparam int FREQ_W = 10;
   localparam int TIME_W = 16;
   localparam int BOOST_W = 8;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int SECOND_NS = 1_000_000_000;
   localparam int TICKS_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
   localparam int BOOST_SECONDS_PER_STEP = 1;

   // ************************************************************
   // Reset values and scale factors
   // ************************************************************
   localparam logic [PRESSURE_W-1:0] HIGH_PRESSURE_OFFSET_DEFAULT = 10'h014;
   localparam logic LONG_SEL_RESET = 1'h1;
   localparam int PERCENT_FULL = 100;

   // ************************************************************
   // Sequencer states
   // ************************************************************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUN,
      ST_BOOST,
      ST_SLEEP
   } seq_state_t;

endpackage

// File: verilog/second_timer.sv
// Saturating seconds counter with clock prescaler
`timescale 1ns/1ps
module second_timer #(
   parameter int TIME_W = 16,
   parameter int TICKS = 10_000_000
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic clk_en_in,
   // Control
   input wire logic clear_in,
   input wire logic count_in,
   // Elapsed seconds
   output logic [TIME_W-1:0] seconds_out
);

   localparam int PRE_W = (TICKS > 1) ? $clog2(TICKS) : 1;
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICKS - 1);

   logic [PRE_W-1:0] pre_r;
   logic [TIME_W-1:0] sec_r;

   wire tick = (pre_r == PRE_LAST);
   wire saturated = &sec_r;

   if (TICKS < 1 || TIME_W < 2) begin : g_check
      $error("second_timer: bad parameters");
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         pre_r <= '0;
         sec_r <= '0;
      end else if (clk_en_in) begin
         if (clear_in) begin
            pre_r <= '0;
            sec_r <= '0;
         end else if (count_in) begin
            pre_r <= tick ? '0 : pre_r + PRE_W'(1);
            if (tick && !saturated) begin
               sec_r <= sec_r + TIME_W'(1);
            end
         end
      end
   end

   assign seconds_out = sec_r;

endmodule

// File: verif/pump_sleep_props.sv
// Port checker for the pump sleep and wake sequencer
`timescale 1ns/1ps
module pump_sleep_props #(
   parameter int PRESSURE_W = 10,
   parameter int FREQ_W = 10,
   parameter int TIME_W = 16,
   parameter int BOOST_W = 8,
   parameter int TICKS_PER_SECOND = 4
) (
   // Clock and mode
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic clk_en_in,
   input wire logic cp_mode_in,
   input wire logic digital_mode_in,
   // Settings
   input wire logic [PRESSURE_W-1:0] pressure_in,
   input wire logic switch_reached_in,
   input wire logic [PRESSURE_W-1:0] target_pressure_in,
   input wire logic [PRESSURE_W-1:0] restart_pressure_drop_in,
   input wire logic [PRESSURE_W-1:0] high_pressure_offset_in,
   input wire logic high_pressure_offset_load_in,
   input wire logic [BOOST_W-1:0] boost_amount_in,
   input wire logic [FREQ_W-1:0] out_frequency_in,
   input wire logic [FREQ_W-1:0] min_frequency_in,
   input wire logic [FREQ_W-1:0] max_frequency_in,
   input wire logic [FREQ_W-1:0] sleep_frequency_offset_in,
   input wire logic [TIME_W-1:0] off_time_threshold_in,
   input wire logic [TIME_W-1:0] long_min_on_time_in,
   input wire logic [TIME_W-1:0] short_min_on_time_in,
   // Outputs watched
   input wire logic run_out,
   input wire logic sleep_out,
   input wire logic boost_out,
   input wire logic [PRESSURE_W:0] pressure_target_out,
   input wire logic [FREQ_W:0] speed_limit_out,
   input wire logic cp_active_out,
   input wire logic [TIME_W-1:0] min_on_time_out,
   input wire logic on_time_met_out,
   input wire logic [PRESSURE_W:0] high_pressure_sleep_threshold_out,
   input wire logic [FREQ_W:0] sleep_frequency_threshold_out
);
   // ************************************************************
   // Assertions
   // ************************************************************
   logic up_r;
   always_ff @(posedge sys_clk_in) up_r <= rstn_in;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in || !up_r);

   run_sleep_a: assert property (run_out == !sleep_out) else $error("run and sleep disagree");
   cp_off_a: assert property (!cp_mode_in && clk_en_in |=> run_out && !sleep_out && !boost_out)
      else $error("sequencer not idle without cp mode");
   boost_cond_a: assert property ($rose(boost_out) |-> ($past(digital_mode_in) ? $past(switch_reached_in)
      : $past(pressure_in) == $past(target_pressure_in))) else $error("boost started off target");
   boost_freq_a: assert property ($rose(boost_out) |-> {1'b0, $past(out_frequency_in)}
      < $past(sleep_frequency_threshold_out)) else $error("boost started at high frequency");
   boost_target_a: assert property (boost_out && !$past(digital_mode_in) |-> pressure_target_out
      == {1'b0, $past(target_pressure_in)} + {3'h0, $past(boost_amount_in)}) else $error("boost target wrong");
   boost_speed_a: assert property (boost_out && $past(digital_mode_in) |-> speed_limit_out == (FREQ_W+1)'(
      (32'($past(max_frequency_in)) * (32'd100 + 32'($past(boost_amount_in)))) / 32'd100))
      else $error("boost speed limit wrong");
   wake_analog_a: assert property (sleep_out && cp_mode_in && !digital_mode_in
      && {1'b0, pressure_in} + {1'b0, restart_pressure_drop_in} < {1'b0, target_pressure_in} |=> run_out)
      else $error("no restart on drawdown");
   wake_digital_a: assert property (sleep_out && cp_mode_in && digital_mode_in && !switch_reached_in
      |=> run_out) else $error("no restart on switch");
   high_sleep_a: assert property (cp_active_out && cp_mode_in && !digital_mode_in && run_out
      && !high_pressure_offset_load_in && !$past(high_pressure_offset_load_in) && $stable(target_pressure_in)
      && {1'b0, pressure_in} >= high_pressure_sleep_threshold_out |=> sleep_out)
      else $error("no sleep at high pressure");
   freq_thr_a: assert property (sleep_frequency_threshold_out == {1'b0, $past(min_frequency_in)}
      + {1'b0, $past(sleep_frequency_offset_in)}) else $error("sleep frequency threshold wrong");
   min_on_a: assert property (min_on_time_out == $past(long_min_on_time_in)
      || min_on_time_out == $past(short_min_on_time_in)) else $error("minimum on-time not a setting");

   boost_c: cover property ($rose(boost_out));
   sleep_c: cover property ($rose(sleep_out));
   wake_c: cover property ($fell(sleep_out));
   dig_boost_c: cover property (boost_out && digital_mode_in);
endmodule

bind pump_sleep_wake_controller pump_sleep_props #(.PRESSURE_W(PRESSURE_W), .FREQ_W(FREQ_W), .TIME_W(TIME_W),
   .BOOST_W(BOOST_W), .TICKS_PER_SECOND(TICKS_PER_SECOND)) chk (.sys_clk_in, .rstn_in, .clk_en_in, .cp_mode_in,
   .digital_mode_in, .pressure_in, .switch_reached_in, .target_pressure_in, .restart_pressure_drop_in,
   .high_pressure_offset_in, .high_pressure_offset_load_in, .boost_amount_in, .out_frequency_in, .min_frequency_in,
   .max_frequency_in, .sleep_frequency_offset_in, .off_time_threshold_in, .long_min_on_time_in,
   .short_min_on_time_in, .run_out, .sleep_out, .boost_out, .pressure_target_out, .speed_limit_out, .cp_active_out,
   .min_on_time_out, .on_time_met_out, .high_pressure_sleep_threshold_out, .sleep_frequency_threshold_out);

// File: verif/pump_plant_model.sv
// Pressure plant: running pump tracks the target, stopped tank bleeds down
`timescale 1ns/1ps
module pump_plant_model #(
   parameter logic [9:0] SWITCH_SET = 10'h032
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   // Drive side
   input wire logic run_in,
   input wire logic [10:0] goal_in,
   // Bench override
   input wire logic ext_sel_in,
   input wire logic [9:0] ext_in,
   // Sensor side
   output logic [9:0] pressure_out,
   output logic switch_out
);
   logic [9:0] level_r;
   logic [9:0] level_nxt;
   logic rise;
   assign rise = run_in && ({1'b0, level_r} < goal_in);
   assign level_nxt = rise ? level_r + 10'h001 : (run_in || level_r == 10'h000) ? level_r : level_r - 10'h001;
   always_ff @(posedge sys_clk_in) begin
      level_r <= !rstn_in ? 10'h000 : level_nxt;
   end
   assign pressure_out = ext_sel_in ? ext_in : level_r;
   assign switch_out = pressure_out >= SWITCH_SET;
endmodule

// File: verif/pump_sleep_wake_controller_tb.sv
// Self-checking bench for the pump sleep and wake sequencer
`timescale 1ns/1ps
module pump_sleep_wake_controller_tb;
   // ************************************************************
   // Stimulus and wiring
   // ************************************************************
   logic sys_clk_in = 0, rstn_in = 0, clk_en_in = 1, cp_mode_in = 0, digital_mode_in = 0;
   logic high_pressure_offset_load_in = 0, ext_sel = 0;
   logic [9:0] target_pressure_in = 10'h032, restart_pressure_drop_in = 10'h005, high_pressure_offset_in = 10'h000;
   logic [9:0] ext_p = 10'h000, out_frequency_in = 10'h03C, min_frequency_in = 10'h01E;
   logic [9:0] max_frequency_in = 10'h03C, sleep_frequency_offset_in = 10'h00A;
   logic [7:0] boost_amount_in = 8'h05;
   logic [15:0] off_time_threshold_in = 16'h0064, long_min_on_time_in = 16'h0002, short_min_on_time_in = 16'h0001;
   wire logic [9:0] pressure_in;
   wire logic switch_reached_in;
   logic run_out, sleep_out, boost_out, cp_active_out, on_time_met_out;
   logic [10:0] pressure_target_out, speed_limit_out, high_pressure_sleep_threshold_out;
   logic [10:0] sleep_frequency_threshold_out;
   logic [15:0] min_on_time_out;
   int n_errors = 0, tests_run = 0, cycles = 0;

   always #50 sys_clk_in = ~sys_clk_in;

   pump_sleep_wake_controller #(.TICKS_PER_SECOND(4)) dut (.sys_clk_in, .rstn_in, .clk_en_in, .cp_mode_in,
      .digital_mode_in, .pressure_in, .switch_reached_in, .target_pressure_in, .restart_pressure_drop_in,
      .high_pressure_offset_in, .high_pressure_offset_load_in, .boost_amount_in, .out_frequency_in,
      .min_frequency_in, .max_frequency_in, .sleep_frequency_offset_in, .off_time_threshold_in,
      .long_min_on_time_in, .short_min_on_time_in, .run_out, .sleep_out, .boost_out, .pressure_target_out,
      .speed_limit_out, .cp_active_out, .min_on_time_out, .on_time_met_out, .high_pressure_sleep_threshold_out,
      .sleep_frequency_threshold_out);

   pump_plant_model plant (.sys_clk_in, .rstn_in, .run_in(run_out), .goal_in(pressure_target_out),
      .ext_sel_in(ext_sel), .ext_in(ext_p), .pressure_out(pressure_in), .switch_out(switch_reached_in));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask

   task automatic wait_for(input int which, input logic val);
      int k;
      logic s;
      k = 0;
      s = ~val;
      while (s !== val && k < 300) begin
         tick(1);
         s = (which == 0) ? run_out : (which == 1) ? boost_out : sleep_out;
         k++;
      end
      chk("wait", val, s);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         print_verdict();
      end
   end

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic test_reset;
      tick(3);
      chk("run in reset", 16'h0000, run_out);
      @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      cp_mode_in <= 1'b1;
      tick(2);
      chk("high threshold", 16'h0046, high_pressure_sleep_threshold_out);
      chk("freq threshold", 16'h0028, sleep_frequency_threshold_out);
      $display("test reset done");
   endtask

   task automatic test_analog;
      tick(80);
      chk("no boost at high freq", 16'h0000, boost_out);
      @(posedge sys_clk_in);
      out_frequency_in <= 10'h014;
      wait_for(1, 1'b1);
      chk("pressure at boost", 16'h0032, pressure_in);
      chk("boosted target", 16'h0037, pressure_target_out);
      wait_for(2, 1'b1);
      chk("pressure at sleep", 16'h0037, pressure_in);
      chk("boost ended", 16'h0000, boost_out);
      @(posedge sys_clk_in);
      out_frequency_in <= 10'h03C;
      wait_for(0, 1'b1);
      chk("pressure at wake", 16'h002B, pressure_in);
      tick(2);
      chk("short on-time", short_min_on_time_in, min_on_time_out);
      chk("on-time restarted", 16'h0000, on_time_met_out);
      $display("test analog done");
   endtask

   task automatic test_overpressure;
      @(posedge sys_clk_in);
      high_pressure_offset_in <= 10'h00A;
      high_pressure_offset_load_in <= 1'b1;
      @(posedge sys_clk_in);
      high_pressure_offset_load_in <= 1'b0;
      tick(3);
      chk("loaded threshold", 16'h003C, high_pressure_sleep_threshold_out);
      @(posedge sys_clk_in);
      ext_p <= 10'h03C;
      ext_sel <= 1'b1;
      off_time_threshold_in <= 16'h0000;
      tick(2);
      chk("sleep at high pressure", 16'h0001, sleep_out);
      chk("boost skipped", 16'h0000, boost_out);
      @(posedge sys_clk_in);
      ext_p <= 10'h02C;
      wait_for(0, 1'b1);
      tick(2);
      chk("equal off short", short_min_on_time_in, min_on_time_out);
      $display("test overpressure done");
   endtask

   task automatic test_digital;
      int k;
      @(posedge sys_clk_in);
      ext_sel <= 1'b0;
      digital_mode_in <= 1'b1;
      restart_pressure_drop_in <= 10'h028;
      off_time_threshold_in <= 16'h0000;
      out_frequency_in <= 10'h014;
      wait_for(1, 1'b1);
      chk("boost speed", 16'h003F, speed_limit_out);
      @(posedge sys_clk_in);
      ext_p <= 10'h037;
      ext_sel <= 1'b1;
      #1;
      k = 0;
      while (boost_out === 1'b1 && k < 100) begin
         tick(1);
         k++;
      end
      chk("boost length", 16'h0001, 16'(k >= 19 && k <= 22));
      chk("digital sleep", 16'h0001, sleep_out);
      tick(12);
      @(posedge sys_clk_in);
      ext_sel <= 1'b0;
      wait_for(0, 1'b1);
      chk("drop ignored", 16'h0001, 16'(pressure_in > 10'h00A));
      tick(2);
      chk("long on-time", long_min_on_time_in, min_on_time_out);
      $display("test digital done");
   endtask

   task automatic test_cp_off;
      @(posedge sys_clk_in);
      digital_mode_in <= 1'b0;
      ext_p <= 10'h046;
      ext_sel <= 1'b1;
      tick(3);
      chk("sleep before cp off", 16'h0001, sleep_out);
      @(posedge sys_clk_in);
      cp_mode_in <= 1'b0;
      clk_en_in <= 1'b0;
      tick(2);
      chk("sleep frozen", 16'h0001, sleep_out);
      @(posedge sys_clk_in);
      clk_en_in <= 1'b1;
      tick(1);
      chk("run without cp", 16'h0001, run_out);
      chk("no sleep without cp", 16'h0000, sleep_out);
      tick(1);
      chk("cp inactive", 16'h0000, cp_active_out);
      $display("test cp off done");
   endtask

   initial begin
      test_reset();
      test_analog();
      test_overpressure();
      test_digital();
      test_cp_off();
      print_verdict();
   end
endmodule
